// ### hw/reset_cause_and_system_options.sv
// Reset cause bookkeeping, watchdog service decode and system options
`timescale 1ns/1ps
module reset_cause_and_system_options
  import reset_cause_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire reg_req_type reg_req,
  output logic [7:0]       read_data,
  input  wire logic        reset_pin_n,
  input  wire logic        low_voltage_trip,
  input  wire logic        low_voltage_reset_enable,
  input  wire logic        watchdog_timeout,
  input  wire logic        illegal_opcode,
  input  wire logic        stop_exec,
  input  wire logic        enter_background_instruction,
  input  wire logic        background_mode_enable,
  input  wire logic        illegal_address,
  output logic             mcu_reset,
  output logic             watchdog_restart,
  output options_type      options
);

  core_state_type state;
  core_state_type next_state;

  // Synchronised pin levels
  logic pin_level;
  logic trip_level;

  // Options register view and its control
  logic [7:0]  options_raw;
  options_type opts;
  logic [7:0]  options_reload_value;
  logic        options_write;

  // Reset source decode
  logic        pin_active;
  logic        low_voltage_active;
  logic        opcode_active;
  logic        address_active;
  logic        watchdog_enabled;
  logic        cause_write;
  logic        bad_service_write;
  logic        watchdog_active;
  logic        force_active;
  logic        any_source;
  logic        holding_source;
  logic [7:0]  entry_cause;

  // Reset pin idles high, so it synchronises from one
  level_sync3 #(
    .INIT (1'b1)
  ) pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (reset_pin_n),
    .level  (pin_level)
  );

  // Supply trip comes from an analog comparator
  level_sync3 #(
    .INIT (1'b0)
  ) trip_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (low_voltage_trip),
    .level  (trip_level)
  );

  // Write-once options; reloaded every cycle the device is in reset
  write_once_reg #(
    .INIT       (OPTIONS_RESET_VALUE),
    .WRITE_MASK (OPTIONS_WRITE_MASK)
  ) options_store (
    .clk          (clk),
    .resetn       (resetn),
    .reload       (state.mcu_reset),
    .reload_value (options_reload_value),
    .write        (options_write),
    .write_data   (reg_req.wdata),
    .value        (options_raw)
  );

  assign opts = options_type'(options_raw);

  // Internal resets keep the reset pin role; debug pin comes back
  always_comb begin
    options_reload_value = OPTIONS_RESET_VALUE;
    options_reload_value[0] = opts.reset_pin_enable;
  end

  // Options writes count only while the device runs
  assign options_write = reg_req.wr
                       && (reg_req.sel == SEL_SYSTEM_OPTIONS)
                       && (state.mode == RUNNING);

  // Pin resets only once the shared pin has its reset role
  assign pin_active = opts.reset_pin_enable && !pin_level;

  // Supply trip resets only when enabled from outside
  assign low_voltage_active = low_voltage_reset_enable
                            && trip_level;

  // Disabled stop and background instructions count as illegal
  assign opcode_active = illegal_opcode
                       || (stop_exec && !opts.stop_enable_bit)
                       || (enter_background_instruction
                           && !background_mode_enable);

  assign address_active = illegal_address;

  // Timeout select of zero turns the watchdog off
  assign watchdog_enabled =
    opts.watchdog_timeout_select != WATCHDOG_OFF;

  // Any write to the cause address is a watchdog service attempt
  assign cause_write = reg_req.wr
                     && (reg_req.sel == SEL_RESET_CAUSE)
                     && (state.mode == RUNNING);

  assign bad_service_write = cause_write
                           && watchdog_enabled
                           && (reg_req.wdata != SERVICE_FIRST)
                           && (reg_req.wdata != SERVICE_SECOND);

  assign watchdog_active = (watchdog_enabled && watchdog_timeout)
                         || bad_service_write;

  // Force reset only from the serial debug path, bit 0 set
  assign force_active = reg_req.wr
                      && reg_req.from_debug
                      && (reg_req.sel == SEL_DEBUG_FORCE)
                      && reg_req.wdata[FORCE_BIT]
                      && (state.mode == RUNNING);

  assign any_source = pin_active || low_voltage_active
                    || opcode_active || address_active
                    || watchdog_active || force_active;

  // Pin and supply hold the device in reset while still active
  assign holding_source = pin_active || low_voltage_active;

  // Cause flags caught at reset entry, low-voltage taking priority
  always_comb begin
    entry_cause = 8'h00;
    if (low_voltage_active) begin
      entry_cause[POWER_ON_BIT]    = state.cause[POWER_ON_BIT];
      entry_cause[LOW_VOLTAGE_BIT] = 1'b1;
    end else if (force_active) begin
      entry_cause = 8'h00;
    end else begin
      entry_cause[PIN_BIT]      = pin_active;
      entry_cause[WATCHDOG_BIT] = watchdog_active;
      entry_cause[OPCODE_BIT]   = opcode_active;
      entry_cause[ADDRESS_BIT]  = address_active;
    end
  end

  // Sequencer, watchdog service decode and read data
  always_comb begin
    next_state                  = state;
    next_state.watchdog_restart = 1'b0;
    unique case (state.mode)
      RUNNING: begin
        if (any_source) begin
          // Flags change only here, never by a software write
          next_state.mode          = HOLDING;
          next_state.hold_count    = HOLD_LOAD;
          next_state.mcu_reset     = 1'b1;
          next_state.cause         = entry_cause;
          next_state.service_armed = 1'b0;
        end else if (cause_write) begin
          if (reg_req.wdata == SERVICE_FIRST) begin
            next_state.service_armed = 1'b1;
          end else if (reg_req.wdata == SERVICE_SECOND) begin
            // Second half restarts the count, flags untouched
            next_state.watchdog_restart = state.service_armed;
            next_state.service_armed    = 1'b0;
          end
        end
      end
      HOLDING: begin
        // Minimum hold first, then wait for held sources to go
        if (state.hold_count != '0) begin
          next_state.hold_count = state.hold_count - 1'b1;
        end else if (!holding_source) begin
          next_state.mode      = RUNNING;
          next_state.mcu_reset = 1'b0;
        end
      end
    endcase

    // Read data is registered; reads have no side effects
    if (reg_req.rd) begin
      unique case (reg_req.sel)
        SEL_RESET_CAUSE: begin
          next_state.read_data = state.cause;
        end
        SEL_DEBUG_FORCE: begin
          next_state.read_data = FORCE_READ_VALUE;
        end
        SEL_SYSTEM_OPTIONS: begin
          next_state.read_data = options_raw;
        end
        default: begin
          next_state.read_data = UNMAPPED_READ_VALUE;
        end
      endcase
    end
  end

  // Power-on: device held in reset, power-on flags set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.mode             <= HOLDING;
      state.hold_count       <= HOLD_LOAD;
      state.cause            <= CAUSE_POWER_ON_VALUE;
      state.service_armed    <= 1'b0;
      state.watchdog_restart <= 1'b0;
      state.mcu_reset        <= 1'b1;
      state.read_data        <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign mcu_reset        = state.mcu_reset;
  assign watchdog_restart = state.watchdog_restart;
  assign read_data        = state.read_data;
  assign options          = opts;

endmodule

// ### hw/reset_cause_pkg.sv
// Constants, field layout and carrier types of the reset cause block
// Function
// - Debug forced reset leaves all cause flags clear
// - Bad service value resets while watchdog enabled
// - 0x55 then 0xAA restarts watchdog, flags kept
// - Power-on sets bits 7 and 1 only
// - Low-voltage reset sets bit 1, keeps bit 7
// - Other resets flag each active source only
// - Low reset pin level sets bit 6
// - Watchdog timeout sets bit 5; select 0:0 disables
// - Illegal, disabled stop or background opcode sets bit 4
// - Fetch from unimplemented address sets bit 3
// - Force register: debug writes only, reads 0x00
// - Debug writing bit 0 forces full reset
// - Options register takes first write after reset
// - Options bits 7:6 hold watchdog timeout select
// - Options bit 5 enables stop mode
// - Options bit 2 places I2C pins
// - Options bit 1 picks debug pin, restored each reset
// - Options bit 0 makes reset pin, kept
// - Options bit 4 is spare storage only
package reset_cause_pkg;

  // Register select codes on the register port
  localparam logic [1:0] SEL_RESET_CAUSE      = 2'h0;
  localparam logic [1:0] SEL_DEBUG_FORCE      = 2'h1;
  localparam logic [1:0] SEL_SYSTEM_OPTIONS   = 2'h2;

  // Reset cause field positions
  localparam int POWER_ON_BIT    = 7;
  localparam int PIN_BIT         = 6;
  localparam int WATCHDOG_BIT    = 5;
  localparam int OPCODE_BIT      = 4;
  localparam int ADDRESS_BIT     = 3;
  localparam int LOW_VOLTAGE_BIT = 1;

  // Reset values
  localparam logic [7:0] CAUSE_POWER_ON_VALUE = 8'h82;
  localparam logic [7:0] OPTIONS_RESET_VALUE  = 8'hC2;
  localparam logic [7:0] OPTIONS_WRITE_MASK   = 8'hF7;
  localparam logic [7:0] FORCE_READ_VALUE     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

  // Watchdog service sequence and force bit
  localparam logic [7:0] SERVICE_FIRST        = 8'h55;
  localparam logic [7:0] SERVICE_SECOND       = 8'hAA;
  localparam logic [1:0] WATCHDOG_OFF         = 2'h0;
  localparam int         FORCE_BIT            = 0;

  // Reset hold time, least time so rounded up
  localparam int CLOCK_PERIOD_PS   = 4000;
  localparam int RESET_HOLD_NS     = 100;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int HOLD_COUNT_WIDTH  = 5;
  localparam logic [HOLD_COUNT_WIDTH-1:0] HOLD_LOAD =
    HOLD_COUNT_WIDTH'(RESET_HOLD_CYCLES - 1);

  typedef enum logic {
    RUNNING,
    HOLDING
  } run_state_type;

  // Register port request
  typedef struct packed {
    logic [1:0] sel;
    logic       wr;
    logic       rd;
    logic       from_debug;
    logic [7:0] wdata;
  } reg_req_type;

  // Options register field layout
  typedef struct packed {
    logic [1:0] watchdog_timeout_select;
    logic       stop_enable_bit;
    logic       spare;
    logic       unused;
    logic       i2c_pin_select;
    logic       debug_pin_enable;
    logic       reset_pin_enable;
  } options_type;

  typedef struct packed {
    run_state_type                mode;
    logic [HOLD_COUNT_WIDTH-1:0]  hold_count;
    logic [7:0]                   cause;
    logic                         service_armed;
    logic                         watchdog_restart;
    logic                         mcu_reset;
    logic [7:0]                   read_data;
  } core_state_type;

  typedef struct packed {
    logic [7:0] value;
    logic       locked;
  } once_state_type;

  typedef struct packed {
    logic [2:0] stages;
    logic       level;
  } sync_state_type;

endpackage

// ### hw/level_sync3.sv
// Three-stage synchroniser for an asynchronous pin level
`timescale 1ns/1ps
module level_sync3
  import reset_cause_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level
);

  sync_state_type state;
  sync_state_type next_state;

  // Level moves only once the last two stages agree
  always_comb begin
    next_state           = state;
    next_state.stages[0] = pin;
    next_state.stages[1] = state.stages[0];
    next_state.stages[2] = state.stages[1];
    if (state.stages[1] == state.stages[2]) begin
      next_state.level = state.stages[2];
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{stages: {3{INIT}}, level: INIT};
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;

endmodule

// ### hw/write_once_reg.sv
// Byte register that honours only the first write after a reload
`timescale 1ns/1ps
module write_once_reg
  import reset_cause_pkg::*;
#(
  parameter logic [7:0] INIT       = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       reload,
  input  wire logic [7:0] reload_value,
  input  wire logic       write,
  input  wire logic [7:0] write_data,
  output logic [7:0]      value
);

  once_state_type state;
  once_state_type next_state;

  // Reload reopens the register; first write then locks it
  always_comb begin
    next_state = state;
    if (reload) begin
      next_state.value  = reload_value;
      next_state.locked = 1'b0;
    end else if (write && !state.locked) begin
      next_state.value  = write_data & WRITE_MASK;
      next_state.locked = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{value: INIT, locked: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;

endmodule

// ### bench/reset_cause_properties.sv
// Port assertions of the reset cause and options block
`timescale 1ns/1ps
module reset_cause_properties
  import reset_cause_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire reg_req_type reg_req,
  input  wire logic [7:0]  read_data,
  input  wire logic        low_voltage_trip,
  input  wire logic        low_voltage_reset_enable,
  input  wire logic        watchdog_timeout,
  input  wire logic        illegal_opcode,
  input  wire logic        illegal_address,
  input  wire logic        mcu_reset,
  input  wire logic        watchdog_restart,
  input  wire options_type options
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic run;
  logic cw;
  // Requests only count while out of reset
  assign run = !mcu_reset;
  assign cw  = run && reg_req.wr && reg_req.sel == SEL_RESET_CAUSE;

  bad_write_a: assert property (
    cw && reg_req.wdata != 8'h55 && reg_req.wdata != 8'hAA &&
    options.watchdog_timeout_select != 2'h0 |=> mcu_reset)
    else $error("bad service write did not reset");
  restart_cause_a: assert property (
    watchdog_restart |-> $past(cw && reg_req.wdata == 8'hAA))
    else $error("watchdog restart without service");
  force_reset_a: assert property (
    run && reg_req.wr && reg_req.sel == SEL_DEBUG_FORCE &&
    reg_req.from_debug && reg_req.wdata[0] |=> mcu_reset)
    else $error("host force did not reset");
  force_reads_a: assert property (
    reg_req.rd && reg_req.sel == SEL_DEBUG_FORCE |=> read_data == 8'h00)
    else $error("force register read not zero");
  opcode_reset_a: assert property (
    run && illegal_opcode |=> mcu_reset)
    else $error("bad opcode did not reset");
  address_reset_a: assert property (
    run && illegal_address |=> mcu_reset)
    else $error("bad address did not reset");
  timeout_reset_a: assert property (
    run && watchdog_timeout && options.watchdog_timeout_select != 2'h0
    |=> mcu_reset) else $error("watchdog timeout did not reset");
  low_voltage_a: assert property (
    (low_voltage_reset_enable && low_voltage_trip) [*6] |=> mcu_reset)
    else $error("low supply did not reset");
  options_hold_a: assert property (
    (run && !reg_req.wr) ##1 run |-> $stable(options))
    else $error("options changed without write");
  debug_pin_a: assert property (
    $fell(mcu_reset) |-> options.debug_pin_enable)
    else $error("debug pin not restored");

  // Main scenarios reached
  cover property (watchdog_restart);
  cover property (run ##1 mcu_reset);
  cover property ($fell(mcu_reset));
endmodule

// ### bench/host_port_model.sv
// Software and debug host driving the register port
`timescale 1ns/1ps
module host_port_model
  import reset_cause_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] read_data,
  output reg_req_type     reg_req
);
  // Port idle at start
  initial reg_req = '0;

  // One write held over its taking edge; data inverted once released
  task automatic put(input logic [1:0] s, input logic [7:0] d,
                     input logic dbg);
    @(posedge clk);
    reg_req <= '{sel: s, wr: 1'b1, rd: 1'b0, from_debug: dbg, wdata: d};
    @(posedge clk);
    reg_req.wr    <= 1'b0;
    reg_req.wdata <= ~d;
  endtask

  // One software write to the options register
  task automatic boot(input logic [7:0] d);
    put(SEL_SYSTEM_OPTIONS, d, 1'b0);
  endtask

  // One read, data taken a cycle after the strobe
  task automatic get(input logic [1:0] s, output logic [7:0] v);
    @(posedge clk);
    reg_req.sel <= s;
    reg_req.rd  <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    v = read_data;
  endtask
endmodule

// ### bench/reset_cause_and_system_options_bench.sv
// Self-checking bench of the reset cause and options block
`timescale 1ns/1ps
module reset_cause_and_system_options_bench
  import reset_cause_pkg::*;
;
  logic        clk, resetn;
  reg_req_type reg_req;
  logic [7:0]  read_data;
  logic        reset_pin_n, low_voltage_trip, low_voltage_reset_enable;
  logic        watchdog_timeout, illegal_opcode, stop_exec;
  logic        enter_background_instruction, background_mode_enable;
  logic        illegal_address, mcu_reset, watchdog_restart;
  options_type options;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [7:0]  exp_cause, exp_opts;
  bit          locked;
  logic [7:0]  cause_q[$] = '{8'h10, 8'h08, 8'h20, 8'h10, 8'h10,
                              8'h00, 8'h40, 8'h02, 8'h20};

  reset_cause_and_system_options i_dut (.clk, .resetn, .reg_req,
    .read_data, .reset_pin_n, .low_voltage_trip, .low_voltage_reset_enable,
    .watchdog_timeout, .illegal_opcode, .stop_exec,
    .enter_background_instruction, .background_mode_enable,
    .illegal_address, .mcu_reset, .watchdog_restart, .options);
  host_port_model i_host (.clk, .read_data, .reg_req);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic rc(input string n, input logic [1:0] s,
                    input logic [7:0] e);
    logic [7:0] v;
    i_host.get(s, v);
    check(n, e, v);
  endtask

  // Bounded wait for the reset output to reach a level
  task automatic settle(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && mcu_reset !== lvl; n++) @(posedge clk);
    #1;
    check("mcu_reset", {7'h0, lvl}, {7'h0, mcu_reset});
  endtask

  // Model of the write-once options register
  task automatic wr_opts(input logic [7:0] v);
    i_host.boot(v);
    if (!locked) exp_opts = v & 8'hF7;
    locked = 1'b1;
  endtask

  // Raise one reset source; pin and supply held past the sync delay
  task automatic provoke(input int k, input logic [7:0] d);
    if (k == 5) i_host.put(SEL_DEBUG_FORCE, 8'h01, 1'b1);
    else if (k == 8) i_host.put(SEL_RESET_CAUSE, d, 1'b0);
    else begin
      @(posedge clk);
      case (k)
        0: illegal_opcode <= 1'b1;
        1: illegal_address <= 1'b1;
        2: watchdog_timeout <= 1'b1;
        3: stop_exec <= 1'b1;
        4: enter_background_instruction <= 1'b1;
        6: reset_pin_n <= 1'b0;
        default: {low_voltage_trip, low_voltage_reset_enable} <= 2'b11;
      endcase
      repeat (k > 5 ? 6 : 1) @(posedge clk);
      {illegal_opcode, illegal_address, watchdog_timeout, stop_exec,
       enter_background_instruction, low_voltage_trip,
       low_voltage_reset_enable} <= 7'h00;
      reset_pin_n <= 1'b1;
    end
  endtask

  // Main sequence
  initial begin
    int seed, k;
    logic [7:0] r;
    seed = $urandom(32'h2506);
    {resetn, low_voltage_trip, low_voltage_reset_enable} = 3'b000;
    {watchdog_timeout, illegal_opcode, stop_exec} = 3'b000;
    {enter_background_instruction, background_mode_enable} = 2'b00;
    {illegal_address, locked} = 2'b00;
    reset_pin_n = 1'b1;
    exp_cause = 8'h82;
    exp_opts = 8'hC2;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    settle(1'b0, 100);
    rc("cause", SEL_RESET_CAUSE, exp_cause);
    rc("options", SEL_SYSTEM_OPTIONS, exp_opts);
    rc("force", SEL_DEBUG_FORCE, 8'h00);
    rc("unmapped", 2'h3, 8'h00);
    r = 8'($urandom);
    wr_opts(r);
    wr_opts(~r);
    rc("options", SEL_SYSTEM_OPTIONS, exp_opts);
    check("options port", exp_opts, options);
    i_host.put(SEL_DEBUG_FORCE, 8'h01, 1'b0);
    i_host.put(SEL_RESET_CAUSE, 8'hAA, 1'b0);
    i_host.put(SEL_RESET_CAUSE, 8'h55, 1'b0);
    i_host.put(SEL_RESET_CAUSE, 8'hAA, 1'b0);
    #1;
    check("restart", 8'h01, {7'h0, watchdog_restart});
    @(posedge clk);
    #1;
    check("restart", 8'h00, {7'h0, watchdog_restart});
    check("mcu_reset", 8'h00, {7'h0, mcu_reset});
    rc("cause", SEL_RESET_CAUSE, exp_cause);
    // Every reset source in turn, options rewritten before each but the first
    for (k = 0; k < 9; k++) begin
      wr_opts(8'hC1);
      r = 8'($urandom);
      if (r == 8'h55 || r == 8'hAA) r = 8'h12;
      provoke(k, r);
      settle(1'b1, 10);
      exp_cause = k == 7 ? (exp_cause & 8'h80) | 8'h02 : cause_q[k];
      exp_opts = 8'hC2 | (exp_opts & 8'h01);
      locked = 1'b0;
      settle(1'b0, 100);
      rc("cause", SEL_RESET_CAUSE, exp_cause);
      rc("options", SEL_SYSTEM_OPTIONS, exp_opts);
      check("options port", exp_opts, options);
    end
    // Watchdog off: neither timeout nor bad write resets
    wr_opts(8'h01);
    provoke(2, 8'h00);
    provoke(8, 8'h12);
    repeat (3) @(posedge clk);
    settle(1'b0, 1);
    rc("cause", SEL_RESET_CAUSE, exp_cause);
    final_report();
  end

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule

bind reset_cause_and_system_options reset_cause_properties i_props (
  .clk, .resetn, .reg_req, .read_data, .low_voltage_trip,
  .low_voltage_reset_enable, .watchdog_timeout, .illegal_opcode,
  .illegal_address, .mcu_reset, .watchdog_restart, .options);
